// ---- usb_io_pkg.sv ----
// Constants shared by the USB IO and power control register block
package usb_io_pkg;
  localparam int          ADDR_W      = 32;
  localparam int          DATA_W      = 32;
  localparam int          REG_W       = 8;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_BASE    = 8'h39;
  localparam logic [7:0]  IDX_SET     = 8'h3A;
  localparam logic [7:0]  IDX_CLR     = 8'h3B;
  localparam logic [31:0] ADDR_BASE   = {22'h0, IDX_BASE, 2'h0};
  localparam logic [31:0] ADDR_SET    = {22'h0, IDX_SET, 2'h0};
  localparam logic [31:0] ADDR_CLR    = {22'h0, IDX_CLR, 2'h0};
  // Field positions
  localparam int          SWAP_BIT    = 1;
  localparam int          SER_LVL_LSB = 2;
  localparam int          POS_PU_BIT  = 4;
  localparam int          NEG_PU_BIT  = 5;
  localparam int          USB_LVL_LSB = 6;
  localparam logic [7:0]  RESET_VAL   = 8'h04;
  localparam logic [7:0]  WRITE_MASK  = 8'hFE;
  // Regulator codes: 00 3.3V, 01 3.0V, 10 2.75V, 11 2.5V
  localparam logic [1:0]  LEVEL_3V3   = 2'h0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {WR_BASE, WR_SET, WR_CLR, WR_NONE} wr_kind_t;
endpackage

// ---- pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter
module pin_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  output logic      level
);
  logic s1, s2, s3;
  logic next_level;

  always_comb begin
    next_level = level;
    // Change counts only once the second and third stages agree
    if (s2 == s3) begin
      next_level = s3;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
    end else begin
      s1    <= pin;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
    end
  end
endmodule // pin_sync

// ---- usb_io_power_control_reg.sv ----
// USB IO and power control register with AXI4-Lite slave and pin routing
// Behaviour
// - Readable at all three addresses; write/set/clear
// - Line swap exchanges positive and negative pins
// - Swap also exchanges serial transmit/receive pins
// - Swap never touches audio left/right pins
// - Serial level applied once transmit enable asserts
// - Audio mode holds regulator at 3.3V
// - Pull-up bits; serial mode forces both on
// - USB level field used outside serial and audio modes
module usb_io_power_control_reg (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [usb_io_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  input  wire logic [usb_io_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  output logic [1:0]                         s_axi_bresp,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  input  wire logic [usb_io_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic [usb_io_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  input  wire logic                          uart_mode,
  input  wire logic                          audio_mode,
  input  wire logic                          serial_transmit_enable,
  input  wire logic                          core_dp_out,
  input  wire logic                          core_dm_out,
  input  wire logic                          core_dp_oe,
  input  wire logic                          core_dm_oe,
  output logic                               core_dp_in,
  output logic                               core_dm_in,
  input  wire logic                          serial_tx,
  output logic                               serial_rx,
  input  wire logic                          audio_left,
  input  wire logic                          audio_right,
  output logic                               audio_left_pin,
  output logic                               audio_right_pin,
  input  wire logic                          pin_dp_in,
  input  wire logic                          pin_dm_in,
  output logic                               pin_dp_out,
  output logic                               pin_dm_out,
  output logic                               pin_dp_oe,
  output logic                               pin_dm_oe,
  output logic [1:0]                         regulator_level,
  output logic                               positive_line_detect_pullup,
  output logic                               negative_line_detect_pullup
);
  import usb_io_pkg::*;
  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic [REG_W-1:0]  usb_io_power_management, next_reg;
  logic              aw_held, w_held, next_aw_held, next_w_held;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [REG_W-1:0]  w_byte, next_w_byte;
  logic              w_lane, next_w_lane;
  logic              next_bvalid, next_rvalid;
  logic [1:0]        next_bresp, next_rresp;
  logic [DATA_W-1:0] next_rdata;
  logic              do_write, rd_hit;
  wr_kind_t          wr_kind;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign rd_hit        = (s_axi_araddr == ADDR_BASE) || (s_axi_araddr == ADDR_SET) ||
                         (s_axi_araddr == ADDR_CLR);
  always_comb begin
    unique case (aw_addr)
      ADDR_BASE: wr_kind = WR_BASE;
      ADDR_SET:  wr_kind = WR_SET;
      ADDR_CLR:  wr_kind = WR_CLR;
      default:   wr_kind = WR_NONE;
    endcase
  end
  always_comb begin
    next_reg     = usb_io_power_management;
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_byte  = w_byte;
    next_w_lane  = w_lane;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rresp   = s_axi_rresp;
    next_rdata   = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_byte = s_axi_wdata[REG_W-1:0];
      next_w_lane = s_axi_wstrb[0];
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (wr_kind == WR_NONE) ? RESP_SLVERR : RESP_OKAY;
      // Only byte lane 0 carries the register; other lanes are ignored
      if (w_lane) begin
        unique case (wr_kind)
          WR_BASE: next_reg = w_byte & WRITE_MASK;
          WR_SET:  next_reg = (usb_io_power_management | w_byte) & WRITE_MASK;
          WR_CLR:  next_reg = usb_io_power_management & ~w_byte & WRITE_MASK;
          WR_NONE: next_reg = usb_io_power_management;
        endcase
      end
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
      next_rdata  = rd_hit ? {24'h000000, usb_io_power_management} : 32'h00000000;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usb_io_power_management <= RESET_VAL;
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 32'h00000000;
      w_byte       <= 8'h00;
      w_lane       <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
    end else begin
      usb_io_power_management <= next_reg;
      aw_held      <= next_aw_held;
      w_held       <= next_w_held;
      aw_addr      <= next_aw_addr;
      w_byte       <= next_w_byte;
      w_lane       <= next_w_lane;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp  <= next_rresp;
      s_axi_rdata  <= next_rdata;
    end
  end
  // ****************************************************************
  // Pin routing, regulator level and pull-ups
  // ****************************************************************
  logic       data_line_swap;
  logic [1:0] serial_mode_regulator_level, usb_mode_regulator_level;
  logic       dp_level, dm_level, ser_applied, next_ser_applied;
  logic       next_dp_out, next_dm_out, next_dp_oe, next_dm_oe;
  logic       next_core_dp_in, next_core_dm_in, next_serial_rx;
  logic [1:0] next_level;
  assign data_line_swap              = usb_io_power_management[SWAP_BIT];
  assign serial_mode_regulator_level = usb_io_power_management[SER_LVL_LSB +: 2];
  assign usb_mode_regulator_level    = usb_io_power_management[USB_LVL_LSB +: 2];
  pin_sync u_dp_sync (.aclk(aclk), .aresetn(aresetn), .pin(pin_dp_in), .level(dp_level));
  pin_sync u_dm_sync (.aclk(aclk), .aresetn(aresetn), .pin(pin_dm_in), .level(dm_level));
  always_comb begin
    next_core_dp_in  = data_line_swap ? dm_level : dp_level;
    next_core_dm_in  = data_line_swap ? dp_level : dm_level;
    // Serial receive idles on the positive pin, transmit on the negative
    next_serial_rx   = data_line_swap ? dm_level : dp_level;
    next_ser_applied = uart_mode && (ser_applied || serial_transmit_enable);
    if (audio_mode) begin
      // Audio owns the data pins; transceiver drive released
      next_dp_out = 1'b0;
      next_dm_out = 1'b0;
      next_dp_oe  = 1'b0;
      next_dm_oe  = 1'b0;
      next_level  = LEVEL_3V3;
    end else if (uart_mode) begin
      next_dp_out = data_line_swap ? serial_tx : 1'b0;
      next_dm_out = data_line_swap ? 1'b0 : serial_tx;
      next_dp_oe  = data_line_swap;
      next_dm_oe  = !data_line_swap;
      // Keep the old level until transmit enable, avoiding a glitch on the rail
      next_level  = next_ser_applied ? serial_mode_regulator_level
                                     : usb_mode_regulator_level;
    end else begin
      next_dp_out = data_line_swap ? core_dm_out : core_dp_out;
      next_dm_out = data_line_swap ? core_dp_out : core_dm_out;
      next_dp_oe  = data_line_swap ? core_dm_oe : core_dp_oe;
      next_dm_oe  = data_line_swap ? core_dp_oe : core_dm_oe;
      next_level  = usb_mode_regulator_level;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_dp_out                  <= 1'b0;
      pin_dm_out                  <= 1'b0;
      pin_dp_oe                   <= 1'b0;
      pin_dm_oe                   <= 1'b0;
      core_dp_in                  <= 1'b0;
      core_dm_in                  <= 1'b0;
      serial_rx                   <= 1'b0;
      ser_applied                 <= 1'b0;
      regulator_level             <= LEVEL_3V3;
      audio_left_pin              <= 1'b0;
      audio_right_pin             <= 1'b0;
      positive_line_detect_pullup <= 1'b0;
      negative_line_detect_pullup <= 1'b0;
    end else begin
      pin_dp_out                  <= next_dp_out;
      pin_dm_out                  <= next_dm_out;
      pin_dp_oe                   <= next_dp_oe;
      pin_dm_oe                   <= next_dm_oe;
      core_dp_in                  <= next_core_dp_in;
      core_dm_in                  <= next_core_dm_in;
      serial_rx                   <= next_serial_rx;
      ser_applied                 <= next_ser_applied;
      regulator_level             <= next_level;
      audio_left_pin              <= audio_left;
      audio_right_pin             <= audio_right;
      positive_line_detect_pullup <= usb_io_power_management[POS_PU_BIT] | uart_mode;
      negative_line_detect_pullup <= usb_io_power_management[NEG_PU_BIT] | uart_mode;
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_read_all;
    s_axi_arvalid && s_axi_arready && rd_hit |=>
      s_axi_rvalid && s_axi_rresp == RESP_OKAY &&
      s_axi_rdata == {24'h000000, $past(usb_io_power_management)};
  endproperty
  a_read_all: assert property (p_read_all) else $error("read data wrong");
  property p_base_write;
    do_write && w_lane && wr_kind == WR_BASE |=>
      usb_io_power_management == ($past(w_byte) & WRITE_MASK) && s_axi_bvalid;
  endproperty
  a_base_write: assert property (p_base_write) else $error("base write lost");
  property p_swap_usb;
    !uart_mode && !audio_mode && data_line_swap |=>
      pin_dp_out == $past(core_dm_out) && pin_dm_out == $past(core_dp_out);
  endproperty
  a_swap_usb: assert property (p_swap_usb) else $error("usb swap wrong");
  property p_swap_uart;
    uart_mode && !audio_mode && data_line_swap |=> pin_dp_oe && pin_dp_out == $past(serial_tx);
  endproperty
  a_swap_uart: assert property (p_swap_uart) else $error("serial swap wrong");
  property p_audio_pins;
    audio_mode ##1 audio_mode |-> audio_left_pin == $past(audio_left) &&
      audio_right_pin == $past(audio_right);
  endproperty
  a_audio_pins: assert property (p_audio_pins) else $error("audio pins moved");
  property p_ser_level;
    uart_mode && !audio_mode && serial_transmit_enable |=>
      regulator_level == $past(serial_mode_regulator_level);
  endproperty
  a_ser_level: assert property (p_ser_level) else $error("serial level wrong");
  property p_audio_level;
    audio_mode |=> regulator_level == LEVEL_3V3;
  endproperty
  a_audio_level: assert property (p_audio_level) else $error("audio level wrong");
  property p_pullups;
    uart_mode |=> positive_line_detect_pullup && negative_line_detect_pullup;
  endproperty
  a_pullups: assert property (p_pullups) else $error("pull-ups off in serial");
  property p_usb_level;
    !uart_mode && !audio_mode |=> regulator_level == $past(usb_mode_regulator_level);
  endproperty
  a_usb_level: assert property (p_usb_level) else $error("usb level wrong");
  property p_set_clr;
    do_write && w_lane && (wr_kind == WR_SET || wr_kind == WR_CLR) |=>
      usb_io_power_management == ($past(wr_kind) == WR_SET ?
        (($past(usb_io_power_management) | $past(w_byte)) & WRITE_MASK) :
        ($past(usb_io_power_management) & ~$past(w_byte)));
  endproperty
  a_set_clr: assert property (p_set_clr) else $error("set or clear wrong");
  property p_bit0_zero;
    !usb_io_power_management[0];
  endproperty
  a_bit0_zero: assert property (p_bit0_zero) else $error("bit 0 set");
  c_write: cover property (do_write ##1 s_axi_bvalid && s_axi_bready);
  c_read:  cover property (s_axi_arvalid && s_axi_arready ##1 s_axi_rvalid);
  c_uart:  cover property (uart_mode && data_line_swap && serial_transmit_enable);
  c_audio: cover property (audio_mode && data_line_swap);
endmodule // usb_io_power_control_reg

// ---- usb_link_model.sv ----
// Link controller model: AXI4-Lite master that issues register accesses
module usb_link_model (
  input  wire logic        aclk,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_awaddr,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  input  wire logic [1:0]  s_axi_bresp,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  output logic [31:0]      s_axi_araddr,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = {3{32'h00000000}};
    s_axi_wstrb = 4'h0;
  end
  // Handshakes judged at the falling edge, where no register is moving
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic hs_aw;
    logic hs_w;
    logic b_ok;
    b_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!b_ok) begin
      @(negedge aclk);
      hs_aw = s_axi_awvalid && s_axi_awready;
      hs_w  = s_axi_wvalid && s_axi_wready;
      b_ok  = s_axi_bvalid;
      r     = s_axi_bresp;
      @(posedge aclk);
      // Released payload stops showing the last value
      if (hs_aw) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (hs_w) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic hs;
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      hs   = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      d    = s_axi_rdata;
      r    = s_axi_rresp;
      @(posedge aclk);
      if (hs) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
      end
    end
    s_axi_rready <= 1'b0;
  endtask
endmodule // usb_link_model

// ---- tb_usb_io_power_control_reg.sv ----
// Self-checking bench for the USB IO and power control register
module tb_usb_io_power_control_reg;
  timeunit 1ns;
  timeprecision 1ps;
  import usb_io_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, uart_mode, audio_mode, serial_transmit_enable, core_dp_out;
  logic        core_dm_out, core_dp_oe, core_dm_oe, core_dp_in, core_dm_in, serial_tx;
  logic        serial_rx, audio_left, audio_right, audio_left_pin, audio_right_pin;
  logic        pin_dp_in, pin_dm_in, pin_dp_out, pin_dm_out, pin_dp_oe, pin_dm_oe;
  logic        positive_line_detect_pullup, negative_line_detect_pullup;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, regulator_level;
  int          errors, tests_run, cycles;
  wire [31:0]  level_seen   = {30'h0, regulator_level};
  wire [31:0]  pullups_seen = {30'h0, positive_line_detect_pullup, negative_line_detect_pullup};
  usb_io_power_control_reg u_usb_io_power_control_reg (.*);
  usb_link_model u_usb_link_model (.*);
  // ****************************************
  // Clock, timeout and reporting
  // ****************************************
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("Checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wreg(input logic [31:0] a, input logic [31:0] d, input logic [1:0] re);
    logic [1:0] r;
    u_usb_link_model.wr(a, d, r);
    check("bresp", {30'h0, r}, {30'h0, re});
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] e, input logic [1:0] re);
    logic [31:0] d;
    logic [1:0]  r;
    u_usb_link_model.rd(a, d, r);
    check("rdata", d, e);
    check("rresp", {30'h0, r}, {30'h0, re});
  endtask
  // Outputs are registered, so look at them on a falling edge
  task automatic settle(input int n);
    repeat (n) @(negedge aclk);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rchk(ADDR_BASE, 32'h04, RESP_OKAY);
    rchk(ADDR_SET, 32'h04, RESP_OKAY);
    rchk(ADDR_CLR, 32'h04, RESP_OKAY);
    check("level", level_seen, 32'h0);
    check("pullups", pullups_seen, 32'h0);
    $display("done: reset");
  endtask
  task automatic t_access();
    wreg(ADDR_BASE, 32'hFF, RESP_OKAY);
    rchk(ADDR_BASE, 32'hFE, RESP_OKAY);
    wreg(ADDR_CLR, 32'hF0, RESP_OKAY);
    rchk(ADDR_SET, 32'h0E, RESP_OKAY);
    wreg(ADDR_SET, 32'h11, RESP_OKAY);
    rchk(ADDR_CLR, 32'h1E, RESP_OKAY);
    settle(2);
    // Only the positive pull-up bit set, so a swapped mapping shows
    check("pullups", pullups_seen, 32'h2);
    wreg(32'h000000F0, 32'hFF, RESP_SLVERR);
    rchk(32'h000000F0, 32'h00, RESP_SLVERR);
    rchk(ADDR_BASE, 32'h1E, RESP_OKAY);
    wreg(ADDR_BASE, 32'h00, RESP_OKAY);
    $display("done: access");
  endtask
  task automatic t_swap();
    @(posedge aclk);
    {core_dp_out, core_dm_out, core_dp_oe, core_dm_oe} <= 4'hA;
    {pin_dp_in, pin_dm_in} <= 2'h2;
    settle(8);
    check("pins", 32'({pin_dp_out, pin_dm_out, pin_dp_oe, pin_dm_oe, core_dp_in, core_dm_in}),
          32'h2A);
    wreg(ADDR_SET, 32'hCA, RESP_OKAY);
    settle(8);
    check("pins", 32'({pin_dp_out, pin_dm_out, pin_dp_oe, pin_dm_oe, core_dp_in, core_dm_in}),
          32'h15);
    check("level", level_seen, 32'h3);
    $display("done: swap");
  endtask
  task automatic t_uart();
    @(posedge aclk);
    uart_mode <= 1'b1;
    serial_tx <= 1'b1;
    settle(8);
    check("level", level_seen, 32'h3);
    check("uart", 32'({pin_dp_out, pin_dp_oe, pin_dm_oe, serial_rx}), 32'hC);
    @(posedge aclk);
    serial_transmit_enable <= 1'b1;
    settle(3);
    check("level", level_seen, 32'h2);
    wreg(ADDR_CLR, 32'h02, RESP_OKAY);
    settle(3);
    check("uart", 32'({pin_dm_out, pin_dm_oe, pin_dp_oe, serial_rx}), 32'hD);
    check("pullups", pullups_seen, 32'h3);
    // Leave serial mode through reset
    @(posedge aclk);
    aresetn <= 1'b0;
    uart_mode <= 1'b0;
    serial_transmit_enable <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(ADDR_BASE, 32'h04, RESP_OKAY);
    $display("done: uart");
  endtask
  task automatic t_audio();
    wreg(ADDR_BASE, 32'hC2, RESP_OKAY);
    @(posedge aclk);
    audio_mode <= 1'b1;
    {audio_left, audio_right} <= 2'h2;
    settle(3);
    check("audio", 32'({audio_left_pin, audio_right_pin, pin_dp_oe, pin_dm_oe}), 32'h8);
    check("level", level_seen, 32'h0);
    @(posedge aclk);
    {audio_left, audio_right} <= 2'h1;
    settle(3);
    check("audio", 32'({audio_left_pin, audio_right_pin}), 32'h1);
    $display("done: audio");
  endtask
  initial begin
    {errors, tests_run, cycles} = '0;
    aresetn = 1'b0;
    {uart_mode, audio_mode, serial_transmit_enable, serial_tx} = 4'h0;
    {core_dp_out, core_dm_out, core_dp_oe, core_dm_oe} = 4'h0;
    {audio_left, audio_right, pin_dp_in, pin_dm_in} = 4'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_access();
    t_swap();
    t_uart();
    t_audio();
    test_done();
  end
endmodule // tb_usb_io_power_control_reg
